// ### design/rtctd_pkg.sv
// rtctd_pkg: offsets, field layout, reset values and timing for the rtc time/day registers
// assumes a single 25 MHz clock and a plain strobe register port
package rtctd_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] CLOCK_SECONDS_OFF      = 8'h00;
	localparam logic [7:0] CLOCK_MINUTES_OFF      = 8'h01;
	localparam logic [7:0] CLOCK_HOURS_OFF        = 8'h02;
	localparam logic [7:0] CLOCK_DAY_OF_MONTH_OFF = 8'h03;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [3:0] DATE_UNITS_RST = 4'h1;
	localparam logic [7:0] ZERO8          = 8'h00;

	// ------------------------------------------------------------
	// timing: one second tick at the clock rate
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ         = 25000000;
	localparam int unsigned TICK_PERIOD_S  = 1;
	localparam int unsigned TICK_CYCLES    = CLK_HZ * TICK_PERIOD_S;

	// packed time-of-day digits
	typedef struct packed {
		logic [2:0] secTens;   // 0..5
		logic [3:0] secUnits;  // 0..9
		logic [2:0] minTens;   // 0..5
		logic [3:0] minUnits;  // 0..9
		logic       pm;        // afternoon flag
		logic [1:0] hourTens;  // 0..2
		logic [3:0] hourUnits; // 0..9
		logic [1:0] dateTens;  // 0..3
		logic [3:0] dateUnits; // 0..9
	} rtctd_time_t;

endpackage

// ### design/rtctd_time_day.sv
// rtctd_time_day: seconds, minutes, hours and day-of-month registers with bcd advance
// assumes rst_n is the power-on reset only; general resets are not wired here
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns

module rtctd_time_day #(
	parameter int unsigned TICK_COUNT = rtctd_pkg::TICK_CYCLES // cycles per second
) (
	// clock and power-on reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// register port
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	output logic      [7:0] regRdData,
	// rtc control
	input  wire logic       twelveHourMode, // from rtc control, same clock
	output logic            secondTick      // one-cycle pulse each second
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	rtctd_pkg::rtctd_time_t tod;            // current time and date
	rtctd_pkg::rtctd_time_t next_tod;
	logic [31:0]            divCount;       // one-second divider
	logic [31:0]            next_divCount;
	logic                   next_secondTick;
	logic [7:0]             next_regRdData;
	logic                   tick;           // one-cycle strobe: the divider has run a full second
	// a general reset never reaches this block: only rst_n, the power-on reset, clears the time

	// register images: reserved bits forced low
	// the pm bit reads low outside 12-hour mode even when a stored flag is set
	logic [7:0] secImg;
	logic [7:0] minImg;
	logic [7:0] hourImg;
	logic [7:0] dateImg;
	assign secImg  = {1'b0, tod.secTens, tod.secUnits};
	assign minImg  = {1'b0, tod.minTens, tod.minUnits};
	assign hourImg = {tod.pm & twelveHourMode, 1'b0, tod.hourTens, tod.hourUnits};
	assign dateImg = {2'b00, tod.dateTens, tod.dateUnits};

	// ------------------------------------------------------------
	// next-state: one-second divider
	// ------------------------------------------------------------
	// the divider free-runs from reset; software writes do not restart it, so a freshly
	// written time may see its first advance anywhere up to one second later
	always_comb begin
		next_divCount = divCount + 32'h1;
		tick          = 1'b0;
		if (divCount >= TICK_COUNT - 1) begin
			// end of the second: wrap and strobe the advance
			next_divCount = 32'h0;
			tick          = 1'b1;
		end
		// the registered copy leaves the block as secondTick, in the first cycle that shows the advanced time
		next_secondTick = tick;
	end

	// ------------------------------------------------------------
	// next-state: time advance and software writes
	// ------------------------------------------------------------
	// a write in the tick cycle wins for the written field; other fields still advance
	always_comb begin
		logic dayCarry; // the hours have passed midnight
		dayCarry = 1'b0;
		next_tod = tod;
		if (tick) begin
			if (tod.secUnits != 4'h9) begin
				next_tod.secUnits = tod.secUnits + 4'h1;
			end else begin
				next_tod.secUnits = 4'h0;
				if (tod.secTens != 3'h5) begin
					next_tod.secTens = tod.secTens + 3'h1;
				end else begin
					next_tod.secTens = 3'h0;
					if (tod.minUnits != 4'h9) begin
						next_tod.minUnits = tod.minUnits + 4'h1;
					end else begin
						next_tod.minUnits = 4'h0;
						if (tod.minTens != 3'h5) begin
							next_tod.minTens = tod.minTens + 3'h1;
						end else begin
							next_tod.minTens = 3'h0;
							// hour rollover: 23->00 in 24h, 11->12 flips pm, 12->01 in 12h
							// 12-hour mode counts 12, 01 .. 11; the pm flag flips on the step into 12
							// switching modes does not convert the hours; software rewrites them
							if (twelveHourMode) begin
								if (tod.hourTens == 2'h1 && tod.hourUnits == 4'h2) begin
									next_tod.hourTens  = 2'h0;
									next_tod.hourUnits = 4'h1;
								end else if (tod.hourTens == 2'h1 && tod.hourUnits == 4'h1) begin
									next_tod.hourUnits = 4'h2;
									next_tod.pm        = ~tod.pm;
									// 11 pm into 12 am is midnight: the day moves on
									dayCarry           = tod.pm;
								end else if (tod.hourUnits == 4'h9) begin
									next_tod.hourTens  = tod.hourTens + 2'h1;
									next_tod.hourUnits = 4'h0;
								end else begin
									next_tod.hourUnits = tod.hourUnits + 4'h1;
								end
							end else if (tod.hourTens == 2'h2 && tod.hourUnits == 4'h3) begin
								// 24-hour midnight
								next_tod.hourTens  = 2'h0;
								next_tod.hourUnits = 4'h0;
								dayCarry           = 1'b1;
							end else if (tod.hourUnits == 4'h9) begin
								next_tod.hourTens  = tod.hourTens + 2'h1;
								next_tod.hourUnits = 4'h0;
							end else begin
								next_tod.hourUnits = tod.hourUnits + 4'h1;
							end
							// day carry: month length is not known here, wrap after 31
							if (dayCarry) begin
								if (tod.dateTens == 2'h3 && tod.dateUnits == 4'h1) begin
									// past the 31st: back to the 1st
									next_tod.dateTens  = 2'h0;
									next_tod.dateUnits = rtctd_pkg::DATE_UNITS_RST;
								end else if (tod.dateUnits == 4'h9) begin
									// units wrap, tens carry
									next_tod.dateTens  = tod.dateTens + 2'h1;
									next_tod.dateUnits = 4'h0;
								end else begin
									next_tod.dateUnits = tod.dateUnits + 4'h1;
								end
							end
						end
					end
				end
			end
		end
		// software writes; reserved bits are dropped
		// digits are kept as written with no range check; a bad digit counts on from there
		if (regWrite) begin
			unique case (regAddr)
				rtctd_pkg::CLOCK_SECONDS_OFF: begin
					next_tod.secTens  = regWrData[6:4];
					next_tod.secUnits = regWrData[3:0];
				end
				rtctd_pkg::CLOCK_MINUTES_OFF: begin
					next_tod.minTens  = regWrData[6:4];
					next_tod.minUnits = regWrData[3:0];
				end
				rtctd_pkg::CLOCK_HOURS_OFF: begin
					// the pm flag is only kept in 12-hour mode
					next_tod.pm        = regWrData[7] & twelveHourMode;
					next_tod.hourTens  = regWrData[5:4];
					next_tod.hourUnits = regWrData[3:0];
				end
				rtctd_pkg::CLOCK_DAY_OF_MONTH_OFF: begin
					next_tod.dateTens  = regWrData[5:4];
					next_tod.dateUnits = regWrData[3:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// next-state: read data
	// ------------------------------------------------------------
	// unmapped offsets read zero, and the byte falls back to zero after one cycle
	// so that a stale value is never mistaken for a fresh answer
	always_comb begin
		next_regRdData = rtctd_pkg::ZERO8;
		if (regRead) begin
			unique case (regAddr)
				rtctd_pkg::CLOCK_SECONDS_OFF:      next_regRdData = secImg;
				rtctd_pkg::CLOCK_MINUTES_OFF:      next_regRdData = minImg;
				rtctd_pkg::CLOCK_HOURS_OFF:        next_regRdData = hourImg;
				rtctd_pkg::CLOCK_DAY_OF_MONTH_OFF: next_regRdData = dateImg;
				default:                           next_regRdData = rtctd_pkg::ZERO8;
			endcase
		end
	end

	// ------------------------------------------------------------
	// registers: loaded with reset values by power-on reset only
	// ------------------------------------------------------------
	// divider and tick strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// the second restarts with the time, so the first advance is a full second out
			divCount   <= 32'h0;
			secondTick <= 1'b0;
		end else begin
			divCount   <= next_divCount;
			secondTick <= next_secondTick;
		end
	end

	// time and date digits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// the day units digit is the only non-zero field after reset
			tod           <= '0;
			tod.dateUnits <= rtctd_pkg::DATE_UNITS_RST;
		end else begin
			tod <= next_tod;
		end
	end

	// read data register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdData <= rtctd_pkg::ZERO8;
		end else begin
			regRdData <= next_regRdData;
		end
	end

endmodule

// ### test/rtctd_checker_properties.sv
// rtctd_checker: port properties of the time/day registers
// assumes it is bound onto rtctd_time_day; one clock domain
`timescale 1ns/1ns
module rtctd_checker #(
	parameter int unsigned TICK_COUNT = rtctd_pkg::TICK_CYCLES // cycles per second; the bind passes the design's
) (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic       regRead,
	input wire logic [7:0] regRdData,
	// rtc control
	input wire logic       twelveHourMode,
	input wire logic       secondTick
);
	logic        rdQ;  // a read was taken last cycle
	logic [7:0]  aQ;   // its offset
	logic        mQ;   // mode when it was taken
	logic        seen; // a tick has passed, so gap is a full second
	int unsigned gap;  // cycles since the last tick
	// ----------------------------------------
	// helper registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdQ <= 1'b0;
			aQ <= 8'h00;
			mQ <= 1'b0;
			seen <= 1'b0;
			gap <= 32'h0;
		end else begin
			rdQ <= regRead;
			aQ <= regAddr;
			mQ <= twelveHourMode;
			seen <= seen | secondTick;
			gap <= secondTick ? 32'h1 : gap + 32'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_secTop; rdQ && aQ == 8'h00 |-> !regRdData[7]; endproperty
	a_secTop: assert property (p_secTop) else $error("seconds bit 7 set");
	property p_minTop; rdQ && aQ == 8'h01 |-> !regRdData[7]; endproperty
	a_minTop: assert property (p_minTop) else $error("minutes bit 7 set");
	property p_hrRsv; rdQ && aQ == 8'h02 |-> !regRdData[6]; endproperty
	a_hrRsv: assert property (p_hrRsv) else $error("hours bit 6 set");
	property p_pmOff; rdQ && aQ == 8'h02 && !mQ |-> !regRdData[7]; endproperty
	a_pmOff: assert property (p_pmOff) else $error("pm flag outside 12h mode");
	property p_dayRsv; rdQ && aQ == 8'h03 |-> regRdData[7:6] == 2'h0; endproperty
	a_dayRsv: assert property (p_dayRsv) else $error("day bits 7:6 set");
	// the reset itself is the trigger here, so it cannot disable the check
	property p_inReset; disable iff (1'b0) !rst_n |-> regRdData == 8'h00 && !secondTick; endproperty
	a_inReset: assert property (p_inReset) else $error("outputs active in reset");
	property p_tickGap; secondTick && seen |-> gap == TICK_COUNT; endproperty
	a_tickGap: assert property (p_tickGap) else $error("second period wrong");
	property p_tickPulse; secondTick |=> !secondTick; endproperty
	a_tickPulse: assert property (p_tickPulse) else $error("tick longer than a cycle");
endmodule
bind rtctd_time_day rtctd_checker #(.TICK_COUNT(TICK_COUNT)) chk_i (.clk(clk), .rst_n(rst_n),
	.regAddr(regAddr), .regRead(regRead), .regRdData(regRdData),
	.twelveHourMode(twelveHourMode), .secondTick(secondTick));

// ### test/rtc_time_day_registers_tb_top.sv
// rtc time/day testbench: strobe reads and writes around second ticks
// assumes rtctd_time_day with a short second of 40 cycles
`timescale 1ns/1ns
module rtc_time_day_registers_tb_top;
	logic       clk = 1'b0;
	logic       rst_n;          // driven low at time zero so the reset edge is seen
	logic       regWrite = 1'b0;
	logic       regRead = 1'b0;
	logic       twelveHourMode = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic [7:0] regRdData;
	logic       secondTick;
	int         miscompares = 0;
	int         cmp_count = 0;
	int         cycles = 0;
	// per row: mode, written s m h d, expected s m h d one second later
	logic [7:0] tv [6][9] = '{
		'{8'h00, 8'h59, 8'h59, 8'h23, 8'h31, 8'h00, 8'h00, 8'h00, 8'h01},
		'{8'h01, 8'h59, 8'h59, 8'h11, 8'h05, 8'h00, 8'h00, 8'h92, 8'h05},
		'{8'h01, 8'h59, 8'h59, 8'h92, 8'h05, 8'h00, 8'h00, 8'h81, 8'h05},
		'{8'h01, 8'h59, 8'h59, 8'h91, 8'h15, 8'h00, 8'h00, 8'h12, 8'h16},
		'{8'h00, 8'hD9, 8'hC9, 8'hC5, 8'hF7, 8'h00, 8'h50, 8'h05, 8'h37},
		'{8'h00, 8'h08, 8'h00, 8'h09, 8'h09, 8'h09, 8'h00, 8'h09, 8'h09}};
	rtctd_time_day #(.TICK_COUNT(40)) dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.twelveHourMode(twelveHourMode), .secondTick(secondTick));
	initial forever #20 clk = ~clk;
	// a hang is cut short well past the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			complete_run();
		end
	end
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 chk($sformatf("offset %h", a), regRdData, exp);
	endtask
	task automatic waitTick;
		@(negedge clk);
		while (secondTick !== 1'b1) @(negedge clk);
	endtask
	task automatic resetValues;
		for (int j = 0; j < 4; j++) rd(8'(j), j == 3 ? 8'h01 : 8'h00);
		$display("reset values test done");
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		// a non-blocking low at time zero gives the design a real reset edge
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		resetValues();
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			twelveHourMode <= tv[i][0][0];
			waitTick();
			for (int j = 0; j < 4; j++) wr(8'(j), tv[i][j+1]);
			waitTick();
			for (int j = 0; j < 4; j++) rd(8'(j), tv[i][j+5]);
			$display("rollover row %0d done", i);
		end
		// pm flag: stored only in 12-hour mode, read back only in 12-hour mode
		@(posedge clk);
		twelveHourMode <= 1'b1;
		wr(8'h02, 8'h85);
		rd(8'h02, 8'h85);
		@(posedge clk);
		twelveHourMode <= 1'b0;
		rd(8'h02, 8'h05);
		wr(8'h02, 8'h87);
		@(posedge clk);
		twelveHourMode <= 1'b1;
		rd(8'h02, 8'h07);
		$display("pm flag test done");
		wr(8'h04, 8'hAA);
		rd(8'h04, 8'h00);
		rd(8'hFF, 8'h00);
		$display("unmapped offsets test done");
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		resetValues();
		complete_run();
	end
endmodule
